// ===== common/lsf_regs.vh
// register map, field positions and answer codes of the load status and fault block.
// assumes a request port that already carries decoded modbus function, address and data.
`ifndef LSF_REGS_VH
`define LSF_REGS_VH

// ==========================================================
// register addresses
`define LSF_ADDR_QUES      16'h10b0
`define LSF_ADDR_OPSTAT    16'h10d0
`define LSF_ADDR_FCLEAR    16'h10e0
`define LSF_ADDR_INPUT     16'h1110

// ==========================================================
// function codes and register counts
`define LSF_FC_READ        8'h03
`define LSF_FC_WRITE1      8'h06
`define LSF_CNT_WORD       16'h0002
`define LSF_CNT_DWORD      16'h0004
`define LSF_CNT_ONE        3'h1
`define LSF_CNT_TWO        3'h2
`define LSF_CNT_FOUR       3'h4

// ==========================================================
// exception codes
`define LSF_EXC_NONE       8'h00
`define LSF_EXC_FUNC       8'h01
`define LSF_EXC_ADDR       8'h02
`define LSF_EXC_VALUE      8'h03
`define LSF_EXC_REFUSED    8'h04

// ==========================================================
// boolean write values
`define LSF_VAL_OFF        16'h0000
`define LSF_VAL_ON         16'h0001

// ==========================================================
// questionable word bit positions
`define LSF_Q_OVP          0
`define LSF_Q_OCT          1
`define LSF_Q_OVT          2
`define LSF_Q_OPT          3
`define LSF_Q_OCP          4
`define LSF_Q_OTP          5
`define LSF_Q_RSL          6
`define LSF_Q_REG_LO       7
`define LSF_Q_REG_HI       10
`define LSF_Q_SOFT         11
`define LSF_Q_HARD         12

// ==========================================================
// operation status bit positions
`define LSF_S_STANDBY      0
`define LSF_S_LIVE         1
`define LSF_S_OCT          4
`define LSF_S_OVT          5
`define LSF_S_OPT          6
`define LSF_S_SENSE        7
`define LSF_S_HEALTH_LO    8
`define LSF_S_HEALTH_HI    30
`define LSF_S_OCP          16
`define LSF_S_OVP          17
`define LSF_S_LINHOT       18
`define LSF_S_AVAIL21      21
`define LSF_S_RESHOT       27
`define LSF_S_REG_LO       32
`define LSF_S_REG_HI       35
`define LSF_S_MODE_LO      36
`define LSF_S_MODE_HI      39
`define LSF_S_TEMP         40
`define LSF_S_SOFTSD       41
`define LSF_S_HARDSD       42

// health input index of a status bit is its position minus the low bound
`define LSF_H_OCP          8
`define LSF_H_OVP          9
`define LSF_H_LINHOT       10
`define LSF_H_AVAIL21      13
`define LSF_H_RESHOT       19

`endif

// ===== hdl/lsf_status_fault.v
// status words, fault latch and input enable of the electronic load, behind a request port.
// assumes requests arrive as one-cycle pulses on clk; condition inputs may come from anywhere.
`include "lsf_regs.vh"
`default_nettype none

module lsf_status_fault #(
  parameter HEALTH_W = 23                       // status bits 8 to 30
) (
  input  wire                clk,                 // system clock, 100 MHz
  input  wire                reset_n,             // synchronous reset, active low
  input  wire                req_valid,           // one-cycle request strobe
  input  wire [7:0]          req_func,            // modbus function code
  input  wire [15:0]         req_addr,            // starting register address
  input  wire [15:0]         req_count,           // register count of a read
  input  wire [15:0]         req_wdata,           // value of a single write
  input  wire                overvoltage_protect_hard,   // hard fault condition
  input  wire                overcurrent_protect_hard,   // hard fault condition
  input  wire                sense_loss_hard,            // sense out of bounds
  input  wire                overcurrent_trip_soft,      // soft trip condition
  input  wire                overvoltage_trip_soft,      // soft trip condition
  input  wire                overpower_trip_soft,        // soft trip condition
  input  wire [3:0]          regulation_in,       // current, voltage, resistance, power
  input  wire [3:0]          mode_in,             // range, sense used, lock, analog control
  input  wire [HEALTH_W-1:0] health_in,           // raw status bits 8 to 30
  output reg                 rsp_valid_q,         // one-cycle answer strobe
  output reg                 rsp_exception_q,     // answer is an exception
  output reg  [7:0]          rsp_code_q,          // exception code, zero when none
  output reg  [2:0]          rsp_regs_q,          // registers carried by rsp_data_q
  output reg  [63:0]         rsp_data_q,          // read data, low register pair first
  output reg                 input_on_q,          // input stage conducting
  output reg                 input_hiz_q,         // input stage high impedance
  output reg                 fault_latched_q      // protection latch holds input off
);

  // ==========================================================
  // how the request port behaves
  // - a request is taken at a rising edge with req_valid high
  // - its answer follows at the very next edge, always
  // - rsp_valid_q marks that answer for one cycle only
  // - code, regs and data hold until the next answer
  // - requests may come back to back, one answer each
  // - reads never touch state, whatever their address
  // - an exception answer never touches state either

  // answer codes
  // - none: the request was carried out
  // - bad function: neither read nor single write
  // - illegal address: wrong place or wrong direction
  // - bad value: a count or write value out of range
  // - refused: clear or enable while a fault is present

  // read counts
  // - questionable word: two registers, nothing else
  // - status word: two registers give the low half
  // - status word: four registers give all 64 bits
  // - the word always sits at the low end of rsp_data_q

  // fault latch
  // - any soft or hard condition sets its shutdown flag
  // - a set shutdown flag drops the input at once
  // - a clear only lands once every condition is gone
  // - a condition and a clear in one cycle: set wins
  // - after a clear the input stays off until enabled
  // - an enable is refused while latched or faulted

  // pin conditions
  // - every pin passes two flip-flops before use
  // - so a change shows in the words two edges late
  // - the latch follows one edge after that
  // - sense loss doubles as status bit 7
  // - over temperature: linear or resistor module hot
  // - health pins 8 and 9 are shadowed by hard pins
  // - health pin 13 is forced to zero in the word

  // reset state
  // - input off and high impedance, latch clear
  // - no answer pending, answer fields zero
  // - synchronisers empty

  // limitations
  // - conditions are levels; a glitch shorter than
  //   a clock may be missed, which is accepted
  // - each pin is synchronised alone, so a group of
  //   pins may mix old and new values for a cycle
  // - the input stage is driven from input_on_q and
  //   input_hiz_q, both straight from flip-flops

  // ==========================================================
  // input synchronisers
  localparam RAW_W = HEALTH_W + 14;               // total width of pin conditions

  wire [RAW_W-1:0] raw_in;                        // all pin conditions together
  reg  [RAW_W-1:0] sync1_q;                       // first stage, read only by sync2
  reg  [RAW_W-1:0] sync2_q;                       // second stage, safe to use

  assign raw_in = {health_in, mode_in, regulation_in, overpower_trip_soft,
                   overvoltage_trip_soft, overcurrent_trip_soft, sense_loss_hard,
                   overcurrent_protect_hard, overvoltage_protect_hard};

  // the reset clears both stages, so all conditions
  // read as absent for two edges after reset

  // two flip-flops on every pin condition
  always @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= {RAW_W{1'b0}};
      sync2_q <= {RAW_W{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // live conditions
  // slices of the second synchroniser stage, in the
  // order the pins were packed into raw_in

  wire                ovp_s     = sync2_q[0];     // overvoltage protection
  wire                ocp_s     = sync2_q[1];     // overcurrent protection
  wire                rsl_s     = sync2_q[2];     // sense loss
  wire [2:0]          soft_s    = sync2_q[5:3];   // oct, ovt, opt
  wire [3:0]          reg_s     = sync2_q[9:6];   // regulation state
  wire [3:0]          mode_s    = sync2_q[13:10]; // operating modes
  wire [HEALTH_W-1:0] health_s  = sync2_q[RAW_W-1:14];

  wire otp_s;                                     // combined over temperature
  wire any_soft_fault;                            // or of soft trips
  wire any_hard_fault;                            // or of hard faults
  wire fault_present;                             // any latch source active

  assign otp_s = health_s[`LSF_H_LINHOT] | health_s[`LSF_H_RESHOT];
  assign any_soft_fault = |soft_s;
  assign any_hard_fault = ovp_s | ocp_s | otp_s | rsl_s;
  assign fault_present = any_soft_fault | any_hard_fault;

  // ==========================================================
  // control state
  // enable_q keeps the enable as last written until a set flag clears it; the
  // shutdown flags remember why the input dropped
  // until a clear is accepted

  reg enable_q;                                   // enable as last written, cleared by a set flag
  reg soft_sd_q;                                  // shutdown by soft fault
  reg hard_sd_q;                                  // shutdown by hard fault
  reg enable_d;
  reg soft_sd_d;
  reg hard_sd_d;

  // ==========================================================
  // status words, built live from conditions and state
  reg [31:0] ques_word;                           // questionable word
  reg [63:0] op_word;                             // operation status word

  // both words are rebuilt every cycle from the
  // synchronised pins, input_on_q and the latch flags; nothing
  // here is stored, so a read cannot disturb them
  // status word positions 2, 3, 21, 31 and 43 up stay zero

  // word assembly, unused positions stay zero
  always @* begin
    ques_word = 32'h0000_0000;
    ques_word[`LSF_Q_OVP] = ovp_s;
    ques_word[`LSF_Q_OCP] = ocp_s;
    ques_word[`LSF_Q_OTP] = otp_s;
    ques_word[`LSF_Q_RSL] = rsl_s;
    ques_word[`LSF_Q_OCT] = soft_s[0];
    ques_word[`LSF_Q_OVT] = soft_s[1];
    ques_word[`LSF_Q_OPT] = soft_s[2];
    ques_word[`LSF_Q_REG_HI:`LSF_Q_REG_LO] = reg_s;
    ques_word[`LSF_Q_SOFT] = any_soft_fault;
    ques_word[`LSF_Q_HARD] = any_hard_fault;

    op_word = 64'h0000_0000_0000_0000;
    op_word[`LSF_S_STANDBY] = ~input_on_q;
    op_word[`LSF_S_LIVE] = input_on_q;
    op_word[`LSF_S_OCT] = soft_s[0];
    op_word[`LSF_S_OVT] = soft_s[1];
    op_word[`LSF_S_OPT] = soft_s[2];
    op_word[`LSF_S_SENSE] = rsl_s;
    // bits 10..13, 19, 20, 28, 29 and the rest but 16, 17 and 21 pass straight from the health pins
    op_word[`LSF_S_HEALTH_HI:`LSF_S_HEALTH_LO] = health_s;
    op_word[`LSF_S_AVAIL21] = 1'b0;
    op_word[`LSF_S_OCP] = ocp_s;
    op_word[`LSF_S_OVP] = ovp_s;
    op_word[`LSF_S_REG_HI:`LSF_S_REG_LO] = reg_s;
    op_word[`LSF_S_MODE_HI:`LSF_S_MODE_LO] = mode_s;
    op_word[`LSF_S_TEMP] = otp_s;
    op_word[`LSF_S_SOFTSD] = soft_sd_q;
    op_word[`LSF_S_HARDSD] = hard_sd_q;
  end

  // ==========================================================
  // request decode
  // whole fields are compared; any address other
  // than the four known ones is an illegal address

  wire is_read  = (req_func == `LSF_FC_READ);
  wire is_write = (req_func == `LSF_FC_WRITE1);
  wire at_ques  = (req_addr == `LSF_ADDR_QUES);
  wire at_op    = (req_addr == `LSF_ADDR_OPSTAT);
  wire at_clr   = (req_addr == `LSF_ADDR_FCLEAR);
  wire at_inp   = (req_addr == `LSF_ADDR_INPUT);
  wire val_off  = (req_wdata == `LSF_VAL_OFF);
  wire val_on   = (req_wdata == `LSF_VAL_ON);
  wire latched  = soft_sd_q | hard_sd_q;

  reg        clr_ok;                              // accepted latch release
  reg [7:0]  code_d;                              // answer code
  reg [2:0]  regs_d;                              // registers in answer
  reg [63:0] data_d;                              // answer data

  // answer selection; reads change no state at all
  always @* begin
    clr_ok = 1'b0;
    code_d = `LSF_EXC_NONE;
    regs_d = 3'h0;
    data_d = 64'h0000_0000_0000_0000;
    if (is_read) begin
      if (at_ques) begin
        if (req_count == `LSF_CNT_WORD) begin
          regs_d = `LSF_CNT_TWO;
          data_d = {32'h0000_0000, ques_word};
        end else begin
          code_d = `LSF_EXC_VALUE;
        end
      end else if (at_op) begin
        if (req_count == `LSF_CNT_WORD) begin
          regs_d = `LSF_CNT_TWO;
          data_d = {32'h0000_0000, op_word[31:0]};
        end else if (req_count == `LSF_CNT_DWORD) begin
          regs_d = `LSF_CNT_FOUR;
          data_d = op_word;
        end else begin
          code_d = `LSF_EXC_VALUE;
        end
      end else begin
        code_d = `LSF_EXC_ADDR;
      end
    end else if (is_write) begin
      if (at_clr) begin
        if (val_on) begin
          if (fault_present) begin
            code_d = `LSF_EXC_REFUSED;
          end else begin
            clr_ok = 1'b1;
            regs_d = `LSF_CNT_ONE;
          end
        end else if (val_off) begin
          regs_d = `LSF_CNT_ONE;          // accepted, no action
        end else begin
          code_d = `LSF_EXC_VALUE;
        end
      end else if (at_inp) begin
        if (val_off) begin
          regs_d = `LSF_CNT_ONE;
        end else if (val_on && !latched && !fault_present) begin
          regs_d = `LSF_CNT_ONE;
        end else if (val_on) begin
          code_d = `LSF_EXC_REFUSED;
        end else begin
          code_d = `LSF_EXC_VALUE;
        end
      end else begin
        code_d = `LSF_EXC_ADDR;
      end
    end else begin
      code_d = `LSF_EXC_FUNC;
    end
  end

  // ==========================================================
  // priority inside one cycle, lowest first:
  // - an accepted enable write sets the new enable
  // - an accepted clear drops both shutdown flags
  // - a live soft condition sets the soft flag again
  // - a live hard condition sets the hard flag again
  // - any flag that ends up set forces enable low
  // the decode already refuses a clear while any
  // condition is live, so set-wins is only a guard

  // next control state; a fault always beats a clear or an enable
  always @* begin
    enable_d  = enable_q;
    soft_sd_d = soft_sd_q;
    hard_sd_d = hard_sd_q;
    if (req_valid && is_write && at_inp && (code_d == `LSF_EXC_NONE)) begin
      enable_d = val_on;
    end
    if (req_valid && clr_ok) begin
      soft_sd_d = 1'b0;
      hard_sd_d = 1'b0;
    end
    if (any_soft_fault) begin
      soft_sd_d = 1'b1;
    end
    if (any_hard_fault) begin
      hard_sd_d = 1'b1;
    end
    if (soft_sd_d || hard_sd_d) begin
      enable_d = 1'b0;
    end
  end

  // ==========================================================
  // all outputs come from here, so none glitches;
  // answer fields load only when an answer is due,
  // which keeps the last answer readable

  // state and output registers
  always @(posedge clk) begin
    if (!reset_n) begin
      enable_q        <= 1'b0;
      soft_sd_q       <= 1'b0;
      hard_sd_q       <= 1'b0;
      input_on_q      <= 1'b0;
      input_hiz_q     <= 1'b1;
      fault_latched_q <= 1'b0;
      rsp_valid_q     <= 1'b0;
      rsp_exception_q <= 1'b0;
      rsp_code_q      <= `LSF_EXC_NONE;
      rsp_regs_q      <= 3'h0;
      rsp_data_q      <= 64'h0000_0000_0000_0000;
    end else begin
      enable_q        <= enable_d;
      soft_sd_q       <= soft_sd_d;
      hard_sd_q       <= hard_sd_d;
      input_on_q      <= enable_d;
      input_hiz_q     <= ~enable_d;
      fault_latched_q <= soft_sd_d | hard_sd_d;
      rsp_valid_q     <= req_valid;
      if (req_valid) begin
        // answer registered one cycle after the request
        rsp_exception_q <= (code_d != `LSF_EXC_NONE);
        rsp_code_q      <= code_d;
        rsp_regs_q      <= regs_d;
        rsp_data_q      <= data_d;
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/lsf_status_fault_props.sv
// checker of the request port and input latch of the status block.
// assumes only the block's own ports; attached by the bind at the foot.
`include "lsf_regs.vh"
`default_nettype none
module lsf_status_fault_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic [15:0] req_wdata,
  input wire logic        overcurrent_protect_hard,
  input wire logic        rsp_valid_q,
  input wire logic        rsp_exception_q,
  input wire logic [7:0]  rsp_code_q,
  input wire logic [2:0]  rsp_regs_q,
  input wire logic [63:0] rsp_data_q,
  input wire logic        input_on_q,
  input wire logic        input_hiz_q,
  input wire logic        fault_latched_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // decoded requests
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rd_w  = req_valid && req_func == `LSF_FC_READ;    // any read
  wire wr_w  = req_valid && req_func == `LSF_FC_WRITE1;  // any single write
  wire in_w  = wr_w && req_addr == `LSF_ADDR_INPUT;      // input enable write
  wire on_w  = in_w && req_wdata == `LSF_VAL_ON;         // turn input on
  wire clr_w = wr_w && req_addr == `LSF_ADDR_FCLEAR && req_wdata == `LSF_VAL_ON;
  wire wo_rd = rd_w && (req_addr == `LSF_ADDR_FCLEAR || req_addr == `LSF_ADDR_INPUT);
  // ==========
  // one-cycle read requests and a four-cycle held fault
  sequence ques_rd; rd_w && req_addr == `LSF_ADDR_QUES && req_count == `LSF_CNT_WORD; endsequence
  sequence stat_rd; rd_w && req_addr == `LSF_ADDR_OPSTAT && req_count == `LSF_CNT_DWORD; endsequence
  sequence hard_held; overcurrent_protect_hard [*4]; endsequence
  // ==========
  // assertions
  AST_ANSWER: assert property (req_valid |=> rsp_valid_q)
    else $error("request without answer");
  AST_NO_SPARE: assert property (rsp_valid_q |-> $past(req_valid))
    else $error("answer without request");
  AST_QUES: assert property (ques_rd |=> !rsp_exception_q && rsp_regs_q == `LSF_CNT_TWO
    && rsp_data_q[11] == |rsp_data_q[3:1] && rsp_data_q[12] == |{rsp_data_q[6:4], rsp_data_q[0]})
    else $error("questionable word malformed");
  AST_STAT: assert property (stat_rd |=> rsp_regs_q == `LSF_CNT_FOUR
    && rsp_data_q[63:43] == 21'h0 && rsp_data_q[0] != rsp_data_q[1])
    else $error("status word malformed");
  AST_WRONG_WAY: assert property (wo_rd |=> rsp_code_q == `LSF_EXC_ADDR)
    else $error("read of write-only place accepted");
  AST_HIZ: assert property (input_hiz_q != input_on_q)
    else $error("disabled input not high impedance");
  AST_LATCH_OFF: assert property (fault_latched_q |-> !input_on_q)
    else $error("input on while latched");
  AST_REFUSE: assert property (hard_held ##0 clr_w |=> rsp_code_q == `LSF_EXC_REFUSED)
    else $error("clear accepted while fault present");
  AST_LATCH_SOON: assert property ($rose(overcurrent_protect_hard) |-> ##[1:4] fault_latched_q)
    else $error("fault did not latch");
  AST_ON_CAUSE: assert property ($rose(input_on_q) |-> $past(on_w))
    else $error("input on without enable write");
  AST_OFF: assert property (in_w && req_wdata == `LSF_VAL_OFF |=> !input_on_q)
    else $error("input stays on after off write");
  AST_CLR_CAUSE: assert property ($fell(fault_latched_q) |-> $past(clr_w))
    else $error("latch released without clear");
endmodule
bind lsf_status_fault lsf_status_fault_props u_props (.*);
`default_nettype wire

// ===== test/lsf_master_model.sv
// modbus master model driving the request port of the status block.
// assumes the bench calls its tasks; fields change at the falling edge.
`default_nettype none
module lsf_master_model (
  input  wire logic        clk,
  output var  logic        req_valid,
  output var  logic [7:0]  req_func,
  output var  logic [15:0] req_addr,
  output var  logic [15:0] req_count,
  output var  logic [15:0] req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // idle port at time zero
  initial begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0;
    req_count = 16'h0;
    req_wdata = 16'h0;
  end
  // one value per request, taken at the next rising edge
  task automatic issue(input logic [7:0] f, input logic [15:0] a, c, d);
    @(negedge clk);
    req_valid = 1'b1;
    req_func  = f;
    req_addr  = a;
    req_count = c;
    req_wdata = d;
  endtask
  // release: func, addr and wdata inverted so a stale value never passes for a request
  task automatic idle();
    @(negedge clk);
    req_valid = 1'b0;
    req_func  = ~req_func;
    req_addr  = ~req_addr;
    req_wdata = ~req_wdata;
  endtask
endmodule
`default_nettype wire

// ===== test/lsf_status_fault_bench.sv
// self-checking bench of the status and fault block.
// assumes the master model file and the bound checker.
`default_nettype none
module lsf_status_fault_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] code; logic [2:0] regs; logic [63:0] data, mask;} lsf_exp_t;
  localparam logic [63:0] LO = 64'hffffffff;            // low register pair
  localparam logic [63:0] NOSD = 64'hfffff9ff_ffffffff; // shutdown bits left out
  logic        clk, reset_n, req_valid;                 // clock, reset, strobe
  logic [7:0]  req_func, rsp_code_q;
  logic [15:0] req_addr, req_count, req_wdata;
  logic [5:0]  flt;                                     // ovp oct ovt opt ocp sense
  logic [3:0]  reg_in, mode;                            // regulation, operating mode
  logic [22:0] health;                                  // raw status bits 8 to 30
  logic        rsp_valid_q, rsp_exception_q, input_on_q, input_hiz_q, fault_latched_q;
  logic [2:0]  rsp_regs_q;
  logic [63:0] rsp_data_q;
  lsf_exp_t    q_exp[$];                                // expected answers
  lsf_exp_t    e;
  int          fail_count, cmp_count, i, k;
  integer      seed;
  lsf_status_fault DUT (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_count(req_count), .req_wdata(req_wdata),
    .overvoltage_protect_hard(flt[0]), .overcurrent_trip_soft(flt[1]),
    .overvoltage_trip_soft(flt[2]), .overpower_trip_soft(flt[3]),
    .overcurrent_protect_hard(flt[4]), .sense_loss_hard(flt[5]), .regulation_in(reg_in),
    .mode_in(mode), .health_in(health), .rsp_valid_q(rsp_valid_q),
    .rsp_exception_q(rsp_exception_q), .rsp_code_q(rsp_code_q), .rsp_regs_q(rsp_regs_q),
    .rsp_data_q(rsp_data_q), .input_on_q(input_on_q), .input_hiz_q(input_hiz_q),
    .fault_latched_q(fault_latched_q));
  lsf_master_model u_mst (.clk(clk), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_count(req_count), .req_wdata(req_wdata));
  // ==========
  // expected words from the condition inputs
  function automatic logic [31:0] ques_word();
    logic [31:0] q;
    q = 32'h0;
    q[4:0] = flt[4:0];
    q[5] = health[10] | health[19];
    q[6] = flt[5];
    q[10:7] = reg_in;
    q[11] = |flt[3:1];
    q[12] = flt[0] | flt[4] | q[5] | flt[5];
    return q;
  endfunction
  function automatic logic [63:0] stat_word(input logic on);
    logic [63:0] s;
    s = 64'h0;
    s[30:8] = health;
    s[0] = !on;
    s[1] = on;
    s[6:4] = flt[3:1];
    s[7] = flt[5];
    s[16] = flt[4];
    s[17] = flt[0];
    s[21] = 1'b0;
    s[35:32] = reg_in;
    s[39:36] = mode;
    s[40] = health[10] | health[19];
    return s;
  endfunction
  // ==========
  // compare, request and verdict tasks
  task automatic check(input string n, input logic [63:0] x, s);
    cmp_count++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rq(input logic [7:0] f, input logic [15:0] a, c, d,
                    input logic [7:0] x, input logic [2:0] r, input logic [63:0] v, m);
    q_exp.push_back('{x, r, v, m});
    u_mst.issue(f, a, c, d);
  endtask
  task automatic rd(input logic [15:0] a, c, input logic [7:0] x, input logic [2:0] r,
                    input logic [63:0] v, m);
    rq(8'h03, a, c, 16'h0, x, r, v, m);
  endtask
  task automatic wr(input logic [15:0] a, d, input logic [7:0] x);
    rq(8'h06, a, 16'h0, d, x, 3'h1, 64'h0, 64'h0);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // clock, watchdog and answer scoreboard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    check("run time", 64'h0, 64'h1);
    report_and_stop();
  end
  always @(negedge clk) begin
    if (rsp_valid_q === 1'b1) begin
      e = q_exp.size() != 0 ? q_exp.pop_front() : '{8'hff, 3'h0, 64'h0, 64'h0};
      check("code", e.code, rsp_code_q);
      check("exception", e.code != 8'h0, rsp_exception_q);
      if (e.code == 8'h0) check("regs", e.regs, rsp_regs_q);
      check("data", e.data & e.mask, rsp_data_q & e.mask);
    end
  end
  // ==========
  // main sequence
  initial begin
    seed = 32'ha740;
    reset_n = 1'b0;
    {flt, reg_in, mode, health} = '0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check("input on", 1'b0, input_on_q);
    check("input hiz", 1'b1, input_hiz_q);
    for (i = 0; i < 8; i++) begin
      flt = 6'($random(seed));
      reg_in = 4'($random(seed));
      mode = 4'($random(seed));
      health = 23'($random(seed));
      repeat (4) @(negedge clk);
      rd(16'h10b0, 16'h2, 8'h0, 3'h2, ques_word(), LO);
      rd(16'h10d0, 16'h4, 8'h0, 3'h4, stat_word(0), NOSD);
      rd(16'h10d0, 16'h2, 8'h0, 3'h2, stat_word(0), LO);
      rd(16'h10b0, 16'h2, 8'h0, 3'h2, ques_word(), LO);
      u_mst.idle();
    end
    {flt, health} = '0;
    repeat (4) @(negedge clk);
    rd(16'h10e0, 16'h2, 8'h2, 3'h0, 64'h0, 64'h0);
    rd(16'h1110, 16'h2, 8'h2, 3'h0, 64'h0, 64'h0);
    wr(16'h10b0, 16'h1, 8'h2);
    wr(16'h10d0, 16'h1, 8'h2);
    rq(8'h10, 16'h10b0, 16'h2, 16'h0, 8'h1, 3'h0, 64'h0, 64'h0);
    rd(16'h10b0, 16'h4, 8'h3, 3'h0, 64'h0, 64'h0);
    rd(16'h10d0, 16'h1, 8'h3, 3'h0, 64'h0, 64'h0);
    wr(16'h1110, 16'h2, 8'h3);
    wr(16'h10e0, 16'h0, 8'h0);
    for (k = 0; k < 2; k++) begin
      wr(16'h10e0, 16'h1, 8'h0);
      wr(16'h1110, 16'h1, 8'h0);
      rd(16'h10d0, 16'h4, 8'h0, 3'h4, stat_word(1), ~64'h0);
      u_mst.idle();
      check("input on", 1'b1, input_on_q);
      check("input hiz", 1'b0, input_hiz_q);
      flt = k ? 6'h10 : 6'h02;
      repeat (5) @(negedge clk);
      check("latched", 1'b1, fault_latched_q);
      check("input on", 1'b0, input_on_q);
      wr(16'h10e0, 16'h1, 8'h4);
      wr(16'h1110, 16'h1, 8'h4);
      rd(16'h10d0, 16'h4, 8'h0, 3'h4, stat_word(0) | (64'h1 << (41 + k)), ~64'h0);
      u_mst.idle();
      flt = 6'h0;
      repeat (4) @(negedge clk);
      wr(16'h10e0, 16'h1, 8'h0);
      u_mst.idle();
      check("latched", 1'b0, fault_latched_q);
      check("input on", 1'b0, input_on_q);
      wr(16'h1110, 16'h1, 8'h0);
      wr(16'h1110, 16'h0, 8'h0);
      u_mst.idle();
      check("input on", 1'b0, input_on_q);
    end
    for (i = 0; i < 20 && q_exp.size() != 0; i++) @(negedge clk);
    check("pending answers", 64'h0, q_exp.size());
    report_and_stop();
  end
endmodule
`default_nettype wire
